// ### tmw_pad_model.sv
// Pad model: channel A pin driver gated by the port direction bit, with an external pull-up
`timescale 1ns/1ps
module tmw_pad_model (
  input wire logic wave_pin,
  input wire logic pin_override,
  input wire logic dir_out,
  output logic pad
);
  // The driver is on only while the block owns the pin and the direction bit is set
  // Otherwise the pull-up wins, so a stale wave value never shows at the pad
  assign pad = (pin_override && dir_out) ? wave_pin : 1'b1;
endmodule

// ### tmw_pkg.sv
// Package: register map, field layout and mode codes of the waveform timer
package tmw_pkg;
  localparam logic [7:0] ADDR_CTRL_A = 8'h24;
  localparam logic [7:0] ADDR_CTRL_B = 8'h25;
  localparam logic [7:0] ADDR_COUNT = 8'h26;
  localparam logic [7:0] ADDR_CMP_A = 8'h27;
  localparam logic [7:0] ADDR_CMP_B = 8'h28;
  localparam logic [7:0] ADDR_FLAGS = 8'h15;
  localparam int CHA_MODE_POS = 6;
  localparam int CHB_MODE_POS = 4;
  localparam int GEN_LO_POS = 0;
  localparam int GEN_HI_POS = 3;
  localparam int OVF_POS = 0;
  localparam int MFA_POS = 1;
  localparam int MFB_POS = 2;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'h08;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  typedef enum logic [2:0] {
    TMW_NORMAL = 3'b000,
    TMW_PC_FF = 3'b001,
    TMW_CTC = 3'b010,
    TMW_FAST_FF = 3'b011,
    TMW_RSV4 = 3'b100,
    TMW_PC_CA = 3'b101,
    TMW_RSV6 = 3'b110,
    TMW_FAST_CA = 3'b111
  } tmw_mode_t;
  typedef enum logic [1:0] {
    TMW_OUT_OFF = 2'b00,
    TMW_OUT_TOG = 2'b01,
    TMW_OUT_CLR = 2'b10,
    TMW_OUT_SET = 2'b11
  } tmw_out_t;
endpackage

// ### tmw_timer.sv
// Top: 8-bit timer with mode select, compare buffers and two wave outputs
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module tmw_timer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic wave_pin_a,
  output logic wave_pin_b,
  output logic pin_override_a,
  output logic pin_override_b,
  output logic overflow_flag,
  output logic match_flag_a,
  output logic match_flag_b
);
  import tmw_pkg::*;

  logic [7:0] waveform_control_a;
  logic wave_gen_sel_hi;
  logic [7:0] count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] cmp_buf_a;
  logic [7:0] cmp_buf_b;
  logic count_up;
  logic [2:0] wave_gen_sel;
  tmw_mode_t mode;
  logic is_fast;
  logic is_pc;
  logic is_valid;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic step;
  logic count_wr;
  logic block_match;
  logic [7:0] next_count;
  logic next_up;
  logic upd_buf;
  logic ovf_ev;
  logic flag_wr;

  function automatic logic [7:0] mode_top(input tmw_mode_t m, input logic [7:0] ca);
    case (m)
      TMW_CTC, TMW_PC_CA, TMW_FAST_CA: mode_top = ca;
      default: mode_top = MAX_VAL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign wave_gen_sel = {wave_gen_sel_hi, waveform_control_a[GEN_LO_POS +: 2]};
  assign mode = tmw_mode_t'(wave_gen_sel);
  assign is_fast = mode == TMW_FAST_FF || mode == TMW_FAST_CA;
  assign is_pc = mode == TMW_PC_FF || mode == TMW_PC_CA;
  assign is_valid = mode != TMW_RSV4 && mode != TMW_RSV6;
  assign top_val = mode_top(mode, cmp_buf_a);
  assign at_top = count_value == top_val;
  assign at_bottom = count_value == BOTTOM_VAL;
  // Tick is an enable only; the counter never sees another clock
  assign step = clk_en && timer_tick && is_valid;
  assign count_wr = wr_en && addr == ADDR_COUNT;
  assign match_a = count_value == cmp_buf_a && !block_match;
  assign match_b = count_value == cmp_buf_b && !block_match;

  always_comb begin
    next_count = count_value + 8'h01;
    next_up = count_up;
    if (is_pc) begin
      if (count_up) begin
        if (at_top) begin
          next_count = count_value;
          next_up = 1'b0;
        end
      end else if (at_bottom) begin
        next_count = count_value + 8'h01;
        next_up = 1'b1;
      end else begin
        next_count = count_value - 8'h01;
      end
      if (count_up && at_top && top_val == BOTTOM_VAL) begin
        next_up = 1'b1;
      end
    end else if (at_top) begin
      next_count = BOTTOM_VAL;
      next_up = 1'b1;
    end
  end

  always_comb begin
    case (mode)
      TMW_PC_FF, TMW_PC_CA: upd_buf = at_top && !count_up;
      TMW_FAST_FF, TMW_FAST_CA: upd_buf = at_bottom;
      default: upd_buf = 1'b1;
    endcase
    case (mode)
      TMW_NORMAL, TMW_CTC, TMW_FAST_FF: ovf_ev = count_value == MAX_VAL;
      TMW_PC_FF, TMW_PC_CA: ovf_ev = at_bottom && !count_up;
      TMW_FAST_CA: ovf_ev = at_top;
      default: ovf_ev = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and direction
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_value <= RESET_VAL;
      count_up <= 1'b1;
    end else if (clk_en) begin
      if (count_wr) begin
        count_value <= wdata;
      end else if (step) begin
        count_value <= next_count;
        count_up <= next_up;
      end
    end
  end

  // Write to the counter hides the compare on the following tick
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      block_match <= 1'b0;
    end else if (clk_en) begin
      if (count_wr) begin
        block_match <= 1'b1;
      end else if (step) begin
        block_match <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      waveform_control_a <= RESET_VAL;
      wave_gen_sel_hi <= 1'b0;
      compare_value_a <= RESET_VAL;
      compare_value_b <= RESET_VAL;
    end else if (clk_en && wr_en) begin
      case (addr)
        ADDR_CTRL_A: waveform_control_a <= wdata & CTRL_A_MASK;
        ADDR_CTRL_B: wave_gen_sel_hi <= wdata[GEN_HI_POS];
        ADDR_CMP_A: compare_value_a <= wdata;
        ADDR_CMP_B: compare_value_b <= wdata;
        default: ;
      endcase
    end
  end

  // Double buffer: PWM modes load only at the mode's update point
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmp_buf_a <= RESET_VAL;
      cmp_buf_b <= RESET_VAL;
    end else if (clk_en) begin
      if (!(is_fast || is_pc) || (step && upd_buf)) begin
        cmp_buf_a <= compare_value_a;
        cmp_buf_b <= compare_value_b;
      end
    end
  end

  // Flags: write one clears, a same-cycle event wins
  assign flag_wr = wr_en && addr == ADDR_FLAGS;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
      match_flag_a <= 1'b0;
      match_flag_b <= 1'b0;
    end else if (clk_en) begin
      if (step && ovf_ev) begin
        overflow_flag <= 1'b1;
      end else if (flag_wr && wdata[OVF_POS]) begin
        overflow_flag <= 1'b0;
      end
      if (step && match_a) begin
        match_flag_a <= 1'b1;
      end else if (flag_wr && wdata[MFA_POS]) begin
        match_flag_a <= 1'b0;
      end
      if (step && match_b) begin
        match_flag_b <= 1'b1;
      end else if (flag_wr && wdata[MFB_POS]) begin
        match_flag_b <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= RESET_VAL;
    end else if (clk_en) begin
      rdata <= RESET_VAL;
      if (rd_en) begin
        case (addr)
          ADDR_CTRL_A: rdata <= waveform_control_a;
          ADDR_CTRL_B: rdata <= {4'h0, wave_gen_sel_hi, 3'h0};
          ADDR_COUNT: rdata <= count_value;
          ADDR_CMP_A: rdata <= compare_value_a;
          ADDR_CMP_B: rdata <= compare_value_b;
          ADDR_FLAGS: rdata <= {5'h0, match_flag_b, match_flag_a, overflow_flag};
          default: rdata <= RESET_VAL;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output channels; B never gets the toggle option in PWM modes
  tmw_wave_out u_out_a (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .tick(step),
    .out_mode(waveform_control_a[CHA_MODE_POS +: 2]),
    .tog_allowed(wave_gen_sel_hi),
    .is_fast(is_fast),
    .is_pc(is_pc),
    .is_valid(is_valid),
    .match(match_a),
    .cmp_is_top(cmp_buf_a == top_val),
    .at_bottom(at_bottom),
    .at_top(at_top),
    .count_up(count_up),
    .wave_pin(wave_pin_a),
    .pin_override(pin_override_a)
  );

  tmw_wave_out u_out_b (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .tick(step),
    .out_mode(waveform_control_a[CHB_MODE_POS +: 2]),
    .tog_allowed(1'b0),
    .is_fast(is_fast),
    .is_pc(is_pc),
    .is_valid(is_valid),
    .match(match_b),
    .cmp_is_top(cmp_buf_b == top_val),
    .at_bottom(at_bottom),
    .at_top(at_top),
    .count_up(count_up),
    .wave_pin(wave_pin_b),
    .pin_override(pin_override_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  a_ctrl_rsv_zero: assert property (@(posedge mclk) disable iff (!nrst)
    waveform_control_a[3:2] == 2'b00) else $error("reserved control bits set");
  a_fast_wrap: assert property (@(posedge mclk) disable iff (!nrst)
    (clk_en && step && is_fast && at_top && !count_wr) |=> count_value == BOTTOM_VAL)
    else $error("fast pwm did not wrap");
  a_pc_hold_top: assert property (@(posedge mclk) disable iff (!nrst)
    (clk_en && step && is_pc && count_up && at_top && top_val != 8'h00 && !count_wr)
    |=> (count_value == $past(count_value) && !count_up))
    else $error("phase correct top not held");
  a_pc_down: assert property (@(posedge mclk) disable iff (!nrst)
    (clk_en && step && is_pc && !count_up && !at_bottom && !count_wr)
    |=> count_value == $past(count_value) - 8'h01) else $error("down count wrong");
  a_no_tick_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (!step && !count_wr) |=> $stable(count_value)) else $error("count moved without tick");
  a_rsv_no_drive: assert property (@(posedge mclk) disable iff (!nrst)
    !is_valid |-> (!pin_override_a && !pin_override_b)) else $error("reserved mode drives");
  a_b_rsv_pwm: assert property (@(posedge mclk) disable iff (!nrst)
    ((is_fast || is_pc) && waveform_control_a[5:4] == 2'b01) |-> !pin_override_b)
    else $error("channel b reserved value drives");
  a_ovf_normal: assert property (@(posedge mclk) disable iff (!nrst)
    (clk_en && step && mode == TMW_NORMAL && count_value == MAX_VAL) |=> overflow_flag)
    else $error("overflow not flagged");
  a_fast_bottom_set: assert property (@(posedge mclk) disable iff (!nrst)
    (clk_en && step && is_fast && at_bottom && waveform_control_a[7:6] == 2'b10)
    |=> wave_pin_a) else $error("fast pwm a not set at bottom");
endmodule

// ### tmw_timer_tb.sv
// Testbench: register map, counter sequences and waveform outputs of the timer
`timescale 1ns/1ps
module tmw_timer_tb;
  import tmw_pkg::*;
  logic mclk, nrst, clk_en, timer_tick, wr_en, rd_en, dir_a, pad_a;
  logic [7:0] addr, wdata, rdata, rv;
  logic wave_pin_a, wave_pin_b, pin_override_a, pin_override_b;
  logic overflow_flag, match_flag_a, match_flag_b;
  int err_count, num_checks;

  tmw_timer dut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .timer_tick(timer_tick),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .wave_pin_a(wave_pin_a), .wave_pin_b(wave_pin_b), .pin_override_a(pin_override_a),
    .pin_override_b(pin_override_b), .overflow_flag(overflow_flag),
    .match_flag_a(match_flag_a), .match_flag_b(match_flag_b));
  tmw_pad_model pad (.wave_pin(wave_pin_a), .pin_override(pin_override_a),
    .dir_out(dir_a), .pad(pad_a));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    // Let the register update settle before any caller looks at outputs
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Tick stays high for n edges; results settle just after the last one
  task automatic ticks(input int n);
    @(posedge mclk);
    timer_tick <= 1'b1;
    repeat (n - 1) @(posedge mclk);
    @(posedge mclk);
    timer_tick <= 1'b0;
    #1;
  endtask
  // Compare values go in while non-PWM so the buffers take them at once
  task automatic setup(input logic [7:0] ca, input logic hi, input logic [7:0] cmpa,
                       input logic [7:0] cmpb, input logic [7:0] cnt);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CMP_A, cmpa);
    wr(ADDR_CMP_B, cmpb);
    wr(ADDR_CTRL_B, {4'h0, hi, 3'h0});
    wr(ADDR_CTRL_A, ca);
    wr(ADDR_COUNT, cnt);
    wr(ADDR_FLAGS, 8'h07);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_CTRL_A, rv);
    chk(rv, RESET_VAL);
    rd(ADDR_CTRL_B, rv);
    chk(rv, RESET_VAL);
    wr(ADDR_CTRL_A, 8'hFF);
    rd(ADDR_CTRL_A, rv);
    chk(rv, 8'hF3);
    wr(ADDR_CTRL_A, 8'h00);
    rd(8'h30, rv);
    chk(rv, 8'h00);
    chk(pin_override_a, 1'b0);
  endtask
  task automatic t_nonpwm();
    logic [1:0] om [4] = '{2'b11, 2'b10, 2'b01, 2'b01};
    logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    setup(8'h00, 1'b0, 8'h20, 8'h20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL_A, {om[i], om[i], 4'h0});
      wr(ADDR_COUNT, 8'h1F);
      ticks(2);
      chk(wave_pin_a, ex[i]);
      chk(wave_pin_b, ex[i]);
      chk(pin_override_b, 1'b1);
    end
    rd(ADDR_FLAGS, rv);
    chk(rv, 8'h06);
    wr(ADDR_FLAGS, 8'h07);
    rd(ADDR_FLAGS, rv);
    chk(rv, 8'h00);
  endtask
  // Clear-on-match and fast PWM with compare A as TOP: wrap after count 5
  task automatic t_top();
    logic [7:0] ca [2] = '{8'h82, 8'h83};
    logic hi [2] = '{1'b0, 1'b1};
    logic ex [2] = '{1'b0, 1'b1};
    for (int i = 0; i < 2; i++) begin
      setup(ca[i], hi[i], 8'h05, 8'h40, 8'h03);
      ticks(3);
      rd(ADDR_COUNT, rv);
      chk(rv, BOTTOM_VAL);
      chk(overflow_flag, ex[i]);
      // In fast PWM the top-equal action only lands on the step taken at BOTTOM
      ticks(1);
      chk(wave_pin_a, ex[i]);
    end
  endtask
  task automatic t_fast();
    setup(8'hB3, 1'b0, 8'h10, 8'h10, 8'h0E);
    ticks(3);
    chk(wave_pin_a, 1'b0);
    chk(wave_pin_b, 1'b1);
    chk(overflow_flag, 1'b0);
    wr(ADDR_COUNT, 8'hFE);
    ticks(2);
    chk(overflow_flag, 1'b1);
    rd(ADDR_COUNT, rv);
    chk(rv, BOTTOM_VAL);
    ticks(1);
    chk(wave_pin_a, 1'b1);
    chk(wave_pin_b, 1'b0);
    wr(ADDR_CTRL_A, 8'h53);
    chk(pin_override_a, 1'b0);
    chk(pin_override_b, 1'b0);
  endtask
  task automatic t_pc();
    setup(8'hB1, 1'b0, 8'h10, 8'h10, 8'h0E);
    ticks(3);
    chk(wave_pin_a, 1'b0);
    chk(wave_pin_b, 1'b1);
    wr(ADDR_COUNT, 8'hFD);
    // Up to TOP, one tick held at TOP, then the first step down
    ticks(4);
    rd(ADDR_COUNT, rv);
    chk(rv, 8'hFE);
    chk(overflow_flag, 1'b0);
    ticks(239);
    chk(wave_pin_a, 1'b1);
    chk(wave_pin_b, 1'b0);
    chk(pad_a, 1'b1);
    ticks(16);
    rd(ADDR_COUNT, rv);
    chk(rv, 8'h01);
    chk(overflow_flag, 1'b1);
    @(posedge mclk);
    dir_a <= 1'b0;
    ticks(1);
    chk(pad_a, 1'b1);
    @(posedge mclk);
    dir_a <= 1'b1;
  endtask
  task automatic t_rsv();
    logic [7:0] ca [2] = '{8'h80, 8'h82};
    for (int i = 0; i < 2; i++) begin
      setup(ca[i], 1'b1, 8'h10, 8'h10, 8'h33);
      ticks(5);
      rd(ADDR_COUNT, rv);
      chk(rv, 8'h33);
      chk(pin_override_a, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run is well under a thousand timer ticks plus bus traffic
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_sim();
  end
  initial begin
    err_count = 0;
    num_checks = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    timer_tick = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    dir_a = 1'b1;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_nonpwm();
    t_top();
    t_fast();
    t_pc();
    t_rsv();
    end_sim();
  end
endmodule

// ### tmw_wave_out.sv
// One compare output channel: waveform register and pin override
`timescale 1ns/1ps
module tmw_wave_out (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic [1:0] out_mode,
  input wire logic tog_allowed,
  input wire logic is_fast,
  input wire logic is_pc,
  input wire logic is_valid,
  input wire logic match,
  input wire logic cmp_is_top,
  input wire logic at_bottom,
  input wire logic at_top,
  input wire logic count_up,
  output logic wave_pin,
  output logic pin_override
);
  import tmw_pkg::*;

  logic wave;
  logic tog_ok;
  logic act_ok;
  logic pwm;
  logic special;

  assign tog_ok = out_mode == TMW_OUT_TOG && (!(is_fast || is_pc) || tog_allowed);
  // Reserved modes and reserved field values keep the port function
  assign act_ok = is_valid && (tog_ok || out_mode[1]);
  assign pin_override = act_ok;
  assign pwm = is_fast || is_pc;
  assign special = pwm && out_mode[1] && cmp_is_top;
  assign wave_pin = wave;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wave <= 1'b0;
    end else if (clk_en && tick && act_ok) begin
      if (tog_ok) begin
        if (match) begin
          wave <= !wave;
        end
      end else if (!pwm) begin
        if (match) begin
          wave <= out_mode[0];
        end
      end else if (is_fast) begin
        // Top-equal compare gives constant level, no glitch at top
        if (at_bottom) begin
          wave <= !out_mode[0];
        end else if (match && !special) begin
          wave <= out_mode[0];
        end
      end else begin
        if (special) begin
          if (at_top) begin
            wave <= out_mode[0];
          end
        end else if (match) begin
          wave <= count_up ? out_mode[0] : !out_mode[0];
        end
      end
    end
  end
endmodule
